// ### verification/host_model.sv
`timescale 1ns/10ps
module host_model (
   input wire core_clk, // clock
   input wire [15:0] reg_rdata, // read data
   output logic [4:0] reg_addr = 0, // index
   output logic reg_wr = 0, // write strobe
   output logic reg_rd = 0, // read strobe
   output logic [15:0] reg_wdata = 0 // write data
);
   // call just after a rising edge; after the strobe wr inverts the write data and rd the address
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
      @(posedge core_clk);
   endtask
   task automatic rd(input logic [4:0] a, input bit two,
         output logic [15:0] d1, output logic [15:0] d2);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      if (!two) begin
         reg_rd <= 1'b0;
         reg_addr <= ~a;
      end
      @(posedge core_clk);
      d1 = reg_rdata;
      d2 = d1;
      if (two) begin
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         @(posedge core_clk);
         d2 = reg_rdata;
      end
   endtask
endmodule // host_model

// ### verification/sensor_regs_asserts.sv
`timescale 1ns/10ps
module sensor_regs_asserts (
   input wire core_clk, // clock
   input wire rst, // reset
   input wire [4:0] reg_addr, // index
   input wire reg_wr, // write
   input wire [15:0] reg_wdata, // wdata
   input wire reg_rd, // read
   input wire [15:0] reg_rdata, // rdata
   input wire conv_done, // set done
   input wire [4:0] diag_fail_in, // diag
   input wire trim_err_in, // trim
   input wire regulator_fault_in, // fault
   input wire [15:0] system_flags_in, // sys
   input wire flag_interrupt_enable, // en
   input wire interrupt_latch_enable, // latch
   input wire [7:0] temp_upper_limit, // upper
   input wire [7:0] temp_lower_limit, // lower
   input wire interrupt_out, // irq
   input wire system_diag_read // sys read pulse
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   wire rd_fe = reg_rd && reg_addr == 5'h0d;
   wire fe_set = |diag_fail_in || trim_err_in || regulator_fault_in;
   wire [15:0] lim = {temp_upper_limit, temp_lower_limit};
   property p_lim_rst;
      $fell(rst) |-> lim == 16'h6732;
   endproperty
   a_lim_rst: assert property (p_lim_rst) else $error("bad limits");
   property p_lim_wr;
      reg_wr && reg_addr == 5'h07 |=> lim == $past(reg_wdata);
   endproperty
   a_lim_wr: assert property (p_lim_wr) else $error("limit lost");
   property p_unmapped;
      reg_rd && (reg_addr < 5'h07 || reg_addr > 5'h0e) |=> reg_rdata == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("hole");
   property p_fe_clear;
      rd_fe && !fe_set ##1 rd_fe && !fe_set |=> reg_rdata == 16'h0000;
   endproperty
   a_fe_clear: assert property (p_fe_clear) else $error("kept");
   property p_set_wins;
      rd_fe && diag_fail_in[0] ##1 rd_fe |=> reg_rdata[8];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("lost");
   property p_flag_irq;
      flag_interrupt_enable && |system_flags_in |=> interrupt_out;
   endproperty
   a_flag_irq: assert property (p_flag_irq) else $error("no irq");
   property p_latch;
      interrupt_latch_enable && $past(interrupt_latch_enable) &&
         interrupt_out && !reg_rd && !$past(reg_rd)
         ##1 interrupt_latch_enable |-> interrupt_out;
   endproperty
   a_latch: assert property (p_latch) else $error("irq dropped");
   property p_valid;
      conv_done ##1 reg_rd && reg_addr == 5'h08 |=> reg_rdata[13];
   endproperty
   a_valid: assert property (p_valid) else $error("not valid");
   property p_sys_read;
      reg_rd && reg_addr == 5'h0e |=> system_diag_read;
   endproperty
   a_sys_read: assert property (p_sys_read) else $error("no sys pulse");
   property p_sys_quiet;
      !(reg_rd && reg_addr == 5'h0e) |=> !system_diag_read;
   endproperty
   a_sys_quiet: assert property (p_sys_quiet) else $error("sys pulse");
endmodule // sensor_regs_asserts

// ### verification/testbench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
   fail_count++; $display("unexpected %s exp %h got %h", n, e, s); end end
module testbench;
   logic core_clk = 0, rst = 1, conv_done = 0, conv_start = 0;
   logic trim_err_in = 0, regulator_fault_in = 0, flag_interrupt_enable = 0;
   logic interrupt_latch_enable = 0, result_interrupt_enable = 0;
   logic [4:0] conv_fresh = 0, diag_fail_in = 0, dv;
   logic [15:0] system_flags_in = 0, r[4] = '{default: 0}, d1, d2, w, sysf;
   logic [2:0] cnt = 0;
   wire [15:0] reg_rdata, reg_wdata;
   wire [4:0] reg_addr;
   wire reg_wr, reg_rd, interrupt_out;
   wire [7:0] temp_upper_limit, temp_lower_limit;
   int n_compared = 0, fail_count = 0;
   host_model u_host_model (.*);
   sensor_result_status_regs u_sensor_result_status_regs (.*,
      .first_axis_in(r[0]), .second_axis_in(r[1]), .third_axis_in(r[2]),
      .temperature_in(r[3]), .system_diag_read());
   function automatic logic [15:0] prog(input logic v, input logic [4:0] f,
         input logic [2:0] c);
      return {2'b00, v, f, 1'b0, c, 4'h0};
   endfunction
   task automatic final_report;
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial forever #12.5 core_clk = ~core_clk;
   initial begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      final_report;
   end
   initial begin
      void'($urandom(32'h1bbe));
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      u_host_model.rd(5'h0d, 1, d1, d2);
      `CHK("powerup", 16'h8000, d1)
      `CHK("powerup clear", 16'h0000, d2)
      for (int a = 0; a < 16; a++) begin
         u_host_model.rd(a[4:0], 0, d1, d2);
         `CHK("reset value", a == 7 ? 16'h6732 : 16'h0, d1)
      end
      for (int k = 0; k < 4; k++) begin
         w = $urandom;
         u_host_model.wr(5'h07, w);
         u_host_model.wr(5'h08 + k[4:0], ~w);
         u_host_model.rd(5'h07, 0, d1, d2);
         `CHK("limit word", w, d1)
         `CHK("limit pins", w, {temp_upper_limit, temp_lower_limit})
         u_host_model.rd(5'h08 + k[4:0], 0, d1, d2);
         `CHK("read-only", 16'h0000, d1)
      end
      for (int j = 0; j < 9; j++) begin
         foreach (r[i]) r[i] <= $urandom;
         dv = $urandom;
         conv_fresh <= dv;
         conv_done <= 1'b1;
         @(posedge core_clk);
         conv_done <= 1'b0;
         cnt++;
         u_host_model.rd(5'h08, 0, d1, d2);
         `CHK("progress", prog(1, dv, cnt), d1)
         conv_start <= 1'b1;
         foreach (r[i]) r[i] <= ~r[i];
         @(posedge core_clk);
         conv_start <= 1'b0;
         u_host_model.rd(5'h08, 0, d1, d2);
         `CHK("stale", prog(0, 0, cnt), d1)
         for (int i = 0; i < 4; i++) begin
            u_host_model.rd(5'h09 + i[4:0], 0, d1, d2);
            `CHK("result", ~r[i], d1)
         end
      end
      flag_interrupt_enable <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         dv = k[1] ? 5'($urandom) | 5'h01 : 5'h00;
         sysf = k[0] ? 16'($urandom) | 16'h0001 : 16'h0000;
         w = {3'b000, dv, 6'h00, k[2], k[1] & k[0]};
         diag_fail_in <= dv;
         trim_err_in <= k[2];
         regulator_fault_in <= k[1] & k[0];
         system_flags_in <= sysf;
         @(posedge core_clk);
         diag_fail_in <= 5'h00;
         trim_err_in <= 1'b0;
         regulator_fault_in <= 1'b0;
         u_host_model.rd(5'h08, 0, d1, d2);
         `CHK("cause", {|sysf, |w}, d1[1:0])
         `CHK("flag irq", |{sysf, w}, interrupt_out)
         u_host_model.rd(5'h0d, 1, d1, d2);
         `CHK("diag flags", w, d1)
         `CHK("diag clear", 16'h0000, d2)
      end
      system_flags_in <= 16'h0000;
      fork
         u_host_model.rd(5'h0d, 1, d1, d2);
         begin
            diag_fail_in <= 5'h01;
            @(posedge core_clk);
            diag_fail_in <= 5'h00;
         end
      join
      `CHK("set wins", 16'h0100, d2)
      flag_interrupt_enable <= 1'b0;
      result_interrupt_enable <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         interrupt_latch_enable <= k[0];
         conv_done <= 1'b1;
         @(posedge core_clk);
         conv_done <= 1'b0;
         repeat (3) @(posedge core_clk);
         `CHK("latched irq", k[0], interrupt_out)
         u_host_model.rd(5'h09, 0, d1, d2);
         @(posedge core_clk);
         `CHK("irq released", 1'b0, interrupt_out)
      end
      final_report;
   end
endmodule // testbench
bind sensor_result_status_regs sensor_regs_asserts u_chk (.*);

// ### verilog/diag_flag_bank.v
`timescale 1ns/10ps
// sticky clear-on-read flags, one per bit; set beats clear
module diag_flag_bank #(
   parameter WIDTH = 7
) (
   input wire core_clk, // system clock
   input wire rst, // sync reset, active high
   input wire [WIDTH-1:0] reset_value, // constant value taken at reset
   input wire [WIDTH-1:0] set_in, // one-cycle set pulses
   input wire clear_in, // read strobe clears all
   output reg [WIDTH-1:0] flags // sticky flag state
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
         always @(posedge core_clk) begin
            if (rst) begin
               flags[i] <= reset_value[i];
            end else if (set_in[i]) begin
               flags[i] <= 1'b1;
            end else if (clear_in) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule // diag_flag_bank

// ### verilog/sensor_regs_consts.vh
`ifndef SENSOR_REGS_CONSTS_VH
`define SENSOR_REGS_CONSTS_VH
// ---------------------------------------------
// register offsets (word index on the register port)
// ---------------------------------------------
`define OFS_TEMP_LIMIT 5'h07
`define OFS_CONV_PROGRESS 5'h08
`define OFS_FIRST_AXIS 5'h09
`define OFS_SECOND_AXIS 5'h0a
`define OFS_THIRD_AXIS 5'h0b
`define OFS_TEMPERATURE 5'h0c
`define OFS_FRONTEND_DIAG 5'h0d
`define OFS_SYSTEM_DIAG 5'h0e
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define RST_TEMP_LIMIT 16'h6732
`define RST_UPPER_LIMIT 8'h67
`define RST_LOWER_LIMIT 8'h32
`define RST_RESULT 16'h0000
`define RST_FRONTEND_DIAG 16'h8000
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define UPPER_LIMIT_MSB 15
`define UPPER_LIMIT_LSB 8
`define LOWER_LIMIT_MSB 7
`define LOWER_LIMIT_LSB 0
`define RESULTS_VALID_BIT 13
`define FRESH_MSB 12
`define FRESH_LSB 8
`define SET_COUNT_MSB 6
`define SET_COUNT_LSB 4
`define CAUSE_MSB 1
`define CAUSE_LSB 0
`define POWER_UP_BIT 15
`define DIAG_FAIL_MSB 12
`define DIAG_FAIL_LSB 8
`define TRIM_ERR_BIT 1
`define REG_FAULT_BIT 0
// ---------------------------------------------
// interrupt cause codes
// ---------------------------------------------
`define CAUSE_NONE 2'h0
`define CAUSE_FRONTEND 2'h1
`define CAUSE_SYSTEM 2'h2
`define CAUSE_BOTH 2'h3
`endif

// ### verilog/sensor_result_status_regs.v
// How it works
// - Limits are 8-bit two's complement bytes, 4.267 C a step.
// - Reset loads upper limit 67h and lower limit 32h.
// - Valid bit 13 sets on valid data; results hold while it is clear.
// - Bits 12..8 flag angle, temperature, Z, Y and X data as current.
// - Bits 6:4 count completed data sets and wrap.
// - Bits 1:0 give the interrupt cause: none, front-end, system, both.
// - Axis and temperature results are read-only 16-bit, zero at reset.
// - Power-up bit 15 sets after reset, clears on front-end status read.
// - Front-end status bits 12..8 are clear-on-read diagnostic fails.
// - Bit 1 trim error and bit 0 regulator fault are clear-on-read.
// - With latching on, interrupt holds until any status or result register is read.
// - With flag interrupts on, any status bit set raises the interrupt.
`timescale 1ns/10ps
`include "sensor_regs_consts.vh"
module sensor_result_status_regs (
   input wire core_clk, // 40 MHz system clock
   input wire rst, // sync reset, active high
   input wire [4:0] reg_addr, // register index
   input wire reg_wr, // write strobe, one cycle
   input wire [15:0] reg_wdata, // write data
   input wire reg_rd, // read strobe, one cycle
   output reg [15:0] reg_rdata, // read data, valid cycle after reg_rd
   input wire conv_done, // pulse: conversion set complete, data valid
   input wire conv_start, // pulse: new conversion begins
   input wire [4:0] conv_fresh, // angle,temp,z,y,x current in this set
   input wire [15:0] first_axis_in, // new x result
   input wire [15:0] second_axis_in, // new y result
   input wire [15:0] third_axis_in, // new z result
   input wire [15:0] temperature_in, // new temperature result
   input wire [4:0] diag_fail_in, // pulses: front-end,temp,z,y,x diag fail
   input wire trim_err_in, // pulse: trim data error
   input wire regulator_fault_in, // pulse: regulator fault
   input wire [15:0] system_flags_in, // system status from outside
   input wire flag_interrupt_enable, // any-flag interrupt enable
   input wire interrupt_latch_enable, // latch interrupt until read
   input wire result_interrupt_enable, // interrupt on completed set
   output reg [7:0] temp_upper_limit, // upper temperature limit
   output reg [7:0] temp_lower_limit, // lower temperature limit
   output reg interrupt_out, // interrupt request, active high
   output reg system_diag_read // pulse: system status was read
);
   // ---------------------------------------------
   // result holding and conversion progress
   // ---------------------------------------------
   reg [15:0] first_axis_result;
   reg [15:0] second_axis_result;
   reg [15:0] third_axis_result;
   reg [15:0] temperature_result;
   reg results_valid;
   reg [4:0] fresh;
   reg [2:0] set_count;
   wire rd_frontend;
   wire rd_results;
   wire [6:0] fe_set;
   wire [6:0] fe_flags;
   wire [6:0] fe_reset_value;
   wire frontend_any;
   wire system_any;
   reg [1:0] interrupt_cause_code;
   reg result_event;
   reg interrupt_hold;
   wire interrupt_source;
   wire [15:0] frontend_diag_flags;
   wire [15:0] conversion_progress;
   reg [15:0] next_rdata;
   wire rd_system;
   reg power_up;

   // ---------------------------------------------
   // read decode
   // ---------------------------------------------
   // every status or result read may release a latched interrupt
   assign rd_frontend = reg_rd && (reg_addr == `OFS_FRONTEND_DIAG);
   assign rd_system = reg_rd && (reg_addr == `OFS_SYSTEM_DIAG);
   assign rd_results = reg_rd && (reg_addr == `OFS_CONV_PROGRESS ||
      reg_addr == `OFS_FIRST_AXIS || reg_addr == `OFS_SECOND_AXIS ||
      reg_addr == `OFS_THIRD_AXIS || reg_addr == `OFS_TEMPERATURE);

   // ---------------------------------------------
   // result capture
   // ---------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         first_axis_result <= `RST_RESULT;
         second_axis_result <= `RST_RESULT;
         third_axis_result <= `RST_RESULT;
         temperature_result <= `RST_RESULT;
         results_valid <= 1'b0;
         fresh <= 5'h00;
         set_count <= 3'h0;
      end else if (conv_done) begin
         // results only move on a valid set, so old values stand meanwhile
         first_axis_result <= first_axis_in;
         second_axis_result <= second_axis_in;
         third_axis_result <= third_axis_in;
         temperature_result <= temperature_in;
         results_valid <= 1'b1;
         fresh <= conv_fresh;
         set_count <= set_count + 3'h1;
      end else if (conv_start) begin
         results_valid <= 1'b0;
         fresh <= 5'h00;
      end
   end

   // ---------------------------------------------
   // front-end status flags
   // ---------------------------------------------
   // order: front-end, temp, z, y, x, trim, regulator
   assign fe_set = {diag_fail_in, trim_err_in, regulator_fault_in};
   assign fe_reset_value = 7'h00;

   diag_flag_bank #(
      .WIDTH(7)
   ) u_fe_flags (
      .core_clk(core_clk),
      .rst(rst),
      .reset_value(fe_reset_value),
      .set_in(fe_set),
      .clear_in(rd_frontend),
      .flags(fe_flags)
   );

   // power-up has no set source: only a new reset raises it again
   always @(posedge core_clk) begin
      if (rst) begin
         power_up <= 1'b1;
      end else if (rd_frontend) begin
         power_up <= 1'b0;
      end
   end

   // ---------------------------------------------
   // status words
   // ---------------------------------------------
   assign frontend_diag_flags = {power_up, 2'b00, fe_flags[6:2],
      6'b00_0000, fe_flags[1:0]};
   assign frontend_any = |frontend_diag_flags;
   assign system_any = |system_flags_in;

   // power-up counts as a front-end flag until its first read
   always @* begin
      case ({system_any, frontend_any})
         2'b01: interrupt_cause_code = `CAUSE_FRONTEND;
         2'b10: interrupt_cause_code = `CAUSE_SYSTEM;
         2'b11: interrupt_cause_code = `CAUSE_BOTH;
         default: interrupt_cause_code = `CAUSE_NONE;
      endcase
   end

   assign conversion_progress = {2'b00, results_valid, fresh, 1'b0,
      set_count, 2'b00, interrupt_cause_code};

   // ---------------------------------------------
   // temperature limits
   // ---------------------------------------------
   always @(posedge core_clk) begin
      if (rst) begin
         temp_upper_limit <= `RST_UPPER_LIMIT;
         temp_lower_limit <= `RST_LOWER_LIMIT;
      // limits leave as pins for the threshold comparator outside
      end else if (reg_wr && reg_addr == `OFS_TEMP_LIMIT) begin
         // other offsets are read-only, so writes there drop
         temp_upper_limit <= reg_wdata[15:8];
         temp_lower_limit <= reg_wdata[7:0];
      end
   end

   // ---------------------------------------------
   // interrupt
   // ---------------------------------------------
   // result events interrupt only on the completing cycle
   assign interrupt_source =
      (flag_interrupt_enable && (frontend_any || system_any))
      || (result_interrupt_enable && conv_done);

   always @(posedge core_clk) begin
      if (rst) begin
         interrupt_hold <= 1'b0;
         interrupt_out <= 1'b0;
      end else begin
         // a new source wins over the read that would release it
         if (interrupt_source && interrupt_latch_enable) begin
            interrupt_hold <= 1'b1;
         end else if (rd_frontend || rd_results || rd_system ||
            !interrupt_latch_enable) begin
            interrupt_hold <= 1'b0;
         end
         // registered pin: one cycle behind its source, but glitch free
         interrupt_out <= interrupt_source ||
            (interrupt_hold && interrupt_latch_enable);
      end
   end

   // ---------------------------------------------
   // read path
   // ---------------------------------------------
   always @* begin
      case (reg_addr)
         `OFS_TEMP_LIMIT: next_rdata = {temp_upper_limit, temp_lower_limit};
         `OFS_CONV_PROGRESS: next_rdata = conversion_progress;
         `OFS_FIRST_AXIS: next_rdata = first_axis_result;
         `OFS_SECOND_AXIS: next_rdata = second_axis_result;
         `OFS_THIRD_AXIS: next_rdata = third_axis_result;
         `OFS_TEMPERATURE: next_rdata = temperature_result;
         `OFS_FRONTEND_DIAG: next_rdata = frontend_diag_flags;
         `OFS_SYSTEM_DIAG: next_rdata = system_flags_in;
         default: next_rdata = 16'h0000;
      endcase
   end

   // rdata holds between reads so the host may take it late
   always @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
         system_diag_read <= 1'b0;
      end else begin
         system_diag_read <= rd_system;
         if (reg_rd) begin
            reg_rdata <= next_rdata;
         end
      end
   end
endmodule // sensor_result_status_regs
